// ### verilog/sadc_pkg.sv
package sadc_pkg;

  // Register byte addresses on the bus
  localparam logic [31:0] ADDR_RES_LOW = 32'h0000_0fe0;
  localparam logic [31:0] ADDR_RES_HIGH = 32'h0000_0fe4;
  localparam logic [31:0] ADDR_CH_MODE = 32'h0000_0fe8;
  localparam logic [31:0] ADDR_TIM_LADDER = 32'h0000_0fec;

  // Channel and mode control fields
  localparam int CM_START = 7;
  localparam int CM_MODE_HI = 6;
  localparam int CM_MODE_LO = 5;
  localparam int CM_INDIS = 4;
  localparam int CM_CH_HI = 3;
  localparam logic [7:0] CH_MODE_RST = 8'h00;

  // Timing and ladder control fields
  localparam int TL_LADDER = 5;
  localparam int TL_TIME_HI = 3;
  localparam int TL_TIME_LO = 1;
  localparam int TL_UNDEF_LO = 6;
  localparam logic [7:0] TIM_LADDER_RST = 8'h00;

  // Result low and status fields
  localparam int RS_RES_LO = 6;
  localparam int RS_DONE = 5;
  localparam int RS_BUSY = 4;
  localparam int RES_W = 10;

  // Operating modes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_RSVD = 2'h2;
  localparam logic [1:0] MODE_REPEAT = 2'h3;

  // Conversion time codes, periods doubling from the base
  localparam logic [2:0] TC_39 = 3'h0;
  localparam logic [2:0] TC_78 = 3'h2;
  localparam logic [2:0] TC_156 = 3'h3;
  localparam logic [2:0] TC_312 = 3'h4;
  localparam logic [2:0] TC_624 = 3'h5;
  localparam logic [2:0] TC_1248 = 3'h6;

  // Base conversion time in oscillator periods; the oscillator is REF_CLK
  localparam longint REF_CLK_HZ = 100_000_000;
  localparam longint FC_HZ = REF_CLK_HZ;
  localparam longint CONV_BASE_FC = 39;
  localparam int CONV_BASE_CYC = int'((CONV_BASE_FC * REF_CLK_HZ) / FC_HZ);
  localparam int CNT_W = 11;

endpackage : sadc_pkg

// ### verilog/sadc_conv_timer.sv
module sadc_conv_timer #(
  parameter int CNT_W = sadc_pkg::CNT_W,
  parameter int BASE_CYC = sadc_pkg::CONV_BASE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic start,
  input wire logic abort,
  input wire logic repeat_en,
  input wire logic [2:0] time_code,
  // Status
  output logic busy,
  output logic done
);

  typedef enum logic {TS_IDLE, TS_RUN} sadc_tstate_t;

  typedef struct packed {
    sadc_tstate_t st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] last;
    logic done;
  } sadc_tim_t;

  sadc_tim_t s_r;
  sadc_tim_t s_nxt;
  logic [CNT_W-1:0] period_last;

  // Reserved codes fall back to the longest, safest period
  always_comb begin
    case (time_code)
      sadc_pkg::TC_39: period_last = CNT_W'(BASE_CYC - 1);
      sadc_pkg::TC_78: period_last = CNT_W'((BASE_CYC << 1) - 1);
      sadc_pkg::TC_156: period_last = CNT_W'((BASE_CYC << 2) - 1);
      sadc_pkg::TC_312: period_last = CNT_W'((BASE_CYC << 3) - 1);
      sadc_pkg::TC_624: period_last = CNT_W'((BASE_CYC << 4) - 1);
      default: period_last = CNT_W'((BASE_CYC << 5) - 1);
    endcase
  end

  // Count one conversion; the period is frozen at start
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    case (s_r.st)
      TS_IDLE: begin
        if (start && !abort) begin
          s_nxt.st = TS_RUN;
          s_nxt.cnt = '0;
          s_nxt.last = period_last;
        end
      end
      TS_RUN: begin
        if (abort) begin
          s_nxt.st = TS_IDLE;
        end else if (s_r.cnt == s_r.last) begin
          s_nxt.done = 1'b1;
          s_nxt.cnt = '0;
          if (!repeat_en) begin
            s_nxt.st = TS_IDLE;
          end
        end else begin
          s_nxt.cnt = s_r.cnt + 1'b1;
        end
      end
      default: s_nxt.st = TS_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '{st: TS_IDLE, cnt: '0, last: '0, done: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy = (s_r.st == TS_RUN);
  assign done = s_r.done;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence at_end_s;
    busy && (s_r.cnt == s_r.last) && !abort;
  endsequence

  period_end_a: assert property (at_end_s |=> done)
    else $error("conversion did not end at the selected period");
  done_cause_a: assert property (done |-> $past(busy) && $past(s_r.cnt) == $past(s_r.last))
    else $error("done raised before the period elapsed");

endmodule // sadc_conv_timer

// ### verilog/sadc_ctrl.sv
// What this block does
// - Mode field: 00 off, 01 single start, 11 repeat, 10 reserved.
// - Channel code 0-7 picks input; software changes it only when idle.
// - Input disable bit off enables inputs; set it when none used.
// - Writing start begins a conversion; hardware clears the bit.
// - Standby resets both control registers and blocks writes to them.
// - Time code gives 39 to 1248 oscillator periods; 001, 111 reserved.
// - Ladder bit 0 connects only while converting; 1 always connected.
// - Timing control bits 7 and 6 read undefined; readers ignore them.
// - Done reads 0 before and during conversion, 1 after completion.
// - Reading the high result clears done; read status word first.
// - Busy set at start, cleared at finish and on standby entry.
// - Status word bits 3 to 0 are unstable; readers ignore them.
// - Ten-bit result; status word holds low bits, done and busy.
// - At completion store result, set done and pulse interrupt together.
// - Repeat restarts at once; writing mode off aborts, dropping result.
// - A new start before reading clears done; old result stays readable.
//
// The AHB-Lite interface to the registers is this design's own decision.
module sadc_ctrl (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESET,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  // Power management: high while in a standby mode
  input wire logic STANDBY,
  // Analog macro
  input wire logic [9:0] RESULT_IN,
  output logic [3:0] CHANNEL_SEL,
  output logic INPUT_DISABLE,
  output logic LADDER_ON,
  output logic CONV_ACTIVE,
  output logic CONV_DONE_IRQ
);

  typedef struct packed {
    logic [7:0] ch_mode;
    logic [7:0] tim_ladder;
    logic [sadc_pkg::RES_W-1:0] result;
    logic done;
    logic [sadc_pkg::RES_W-1:0] res_s1;
    logic [sadc_pkg::RES_W-1:0] res_s2;
    logic wr_pend;
    logic rd_pend;
    logic [31:0] addr;
    logic [31:0] rdata;
    logic ready;
    logic irq;
    logic ladder;
  } sadc_main_t;

  sadc_main_t s_r;
  sadc_main_t s_nxt;
  logic t_busy;
  logic t_done;
  logic go;
  logic abort;
  logic addr_take;
  logic wr_cm;
  logic [1:0] mode;
  logic [7:0] status_byte;

  assign mode = s_r.ch_mode[sadc_pkg::CM_MODE_HI:sadc_pkg::CM_MODE_LO];

  // Bus address phase is taken only when the bus is ready
  assign addr_take = HSEL && HTRANS[1] && HREADY;

  // Data phase write to channel and mode control
  assign wr_cm = s_r.wr_pend && !STANDBY
    && (s_r.addr == sadc_pkg::ADDR_CH_MODE);

  // Start only in a valid mode and only from idle
  // A start that meets an abort in the same cycle is not taken
  assign go = s_r.ch_mode[sadc_pkg::CM_START] && !t_busy && !abort
    && (mode == sadc_pkg::MODE_SINGLE
    || mode == sadc_pkg::MODE_REPEAT);

  // Writing mode off or entering standby kills the conversion
  assign abort = STANDBY || (wr_cm
    && HWDATA[sadc_pkg::CM_MODE_HI:sadc_pkg::CM_MODE_LO]
    == sadc_pkg::MODE_OFF);

  // Low result bits, done and busy; unstable low nibble reads as zero
  assign status_byte = {s_r.result[1:0], s_r.done, t_busy,
    4'h0};

  sadc_conv_timer #(
    .CNT_W(sadc_pkg::CNT_W),
    .BASE_CYC(sadc_pkg::CONV_BASE_CYC)
  ) u_timer (
    .clk(REF_CLK),
    .rst(RESET),
    .start(go),
    .abort(abort),
    .repeat_en(mode == sadc_pkg::MODE_REPEAT),
    .time_code(s_r.tim_ladder[sadc_pkg::TL_TIME_HI:sadc_pkg::TL_TIME_LO]),
    .busy(t_busy),
    .done(t_done)
  );

  // Next-state logic for bus, control registers and result
  always_comb begin
    s_nxt = s_r;
    s_nxt.irq = 1'b0;
    s_nxt.wr_pend = 1'b0;
    // Result pins are asynchronous to REF_CLK
    s_nxt.res_s1 = RESULT_IN;
    s_nxt.res_s2 = s_r.res_s1;

    // Address phase; reads take one wait state so a write just before
    // is already visible in the data returned
    if (s_r.rd_pend) begin
      s_nxt.rd_pend = 1'b0;
      s_nxt.ready = 1'b1;
      if (s_r.addr == sadc_pkg::ADDR_RES_LOW) begin
        s_nxt.rdata = {24'h00_0000, status_byte};
      end else if (s_r.addr == sadc_pkg::ADDR_RES_HIGH) begin
        s_nxt.rdata = {24'h00_0000, s_r.result[9:2]};
        s_nxt.done = 1'b0;
      end else if (s_r.addr == sadc_pkg::ADDR_CH_MODE) begin
        s_nxt.rdata = {24'h00_0000, s_r.ch_mode};
      end else if (s_r.addr == sadc_pkg::ADDR_TIM_LADDER) begin
        s_nxt.rdata = {26'h000_0000,
          s_r.tim_ladder[sadc_pkg::TL_UNDEF_LO-1:0]};
      end else begin
        s_nxt.rdata = 32'h0000_0000;
      end
    end else if (addr_take) begin
      s_nxt.addr = HADDR;
      s_nxt.wr_pend = HWRITE;
      s_nxt.rd_pend = !HWRITE;
      s_nxt.ready = HWRITE;
    end

    // Hardware clears the start bit as the conversion begins
    if (go) begin
      s_nxt.ch_mode[sadc_pkg::CM_START] = 1'b0;
      s_nxt.done = 1'b0;
    end

    // Data phase writes; a start written while busy is dropped
    if (wr_cm) begin
      s_nxt.ch_mode[sadc_pkg::CM_START] = HWDATA[sadc_pkg::CM_START]
        && !t_busy && !go;
      s_nxt.ch_mode[sadc_pkg::CM_MODE_HI:sadc_pkg::CM_INDIS] =
        HWDATA[sadc_pkg::CM_MODE_HI:sadc_pkg::CM_INDIS];
      if (!t_busy) begin
        s_nxt.ch_mode[sadc_pkg::CM_CH_HI:0] =
          HWDATA[sadc_pkg::CM_CH_HI:0];
      end
    end else if (s_r.wr_pend && !STANDBY
      && s_r.addr == sadc_pkg::ADDR_TIM_LADDER) begin
      s_nxt.tim_ladder = HWDATA[7:0];
    end

    // Completion: result, done and interrupt in one cycle; set wins
    // over a read that clears done in the same cycle
    if (t_done) begin
      s_nxt.result = s_r.res_s2;
      s_nxt.done = 1'b1;
      s_nxt.irq = 1'b1;
    end

    // Standby forces control back to its initial values
    if (STANDBY) begin
      s_nxt.ch_mode = sadc_pkg::CH_MODE_RST;
      s_nxt.tim_ladder = sadc_pkg::TIM_LADDER_RST;
      s_nxt.result = '0;
      s_nxt.done = 1'b0;
      s_nxt.irq = 1'b0;
    end

    // Ladder follows the bit, or the conversion when the bit is clear
    s_nxt.ladder = s_nxt.tim_ladder[sadc_pkg::TL_LADDER]
      || (t_busy && !abort) || go;
  end

  // State register
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      s_r <= '{ch_mode: sadc_pkg::CH_MODE_RST,
        tim_ladder: sadc_pkg::TIM_LADDER_RST,
        result: '0, done: 1'b0, res_s1: '0, res_s2: '0,
        wr_pend: 1'b0, rd_pend: 1'b0, addr: '0, rdata: '0,
        ready: 1'b1, irq: 1'b0, ladder: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs come straight from flops, except HRESP, which is tied low
  assign HREADYOUT = s_r.ready;
  assign HRESP = 1'b0;
  assign HRDATA = s_r.rdata;
  assign CHANNEL_SEL = s_r.ch_mode[sadc_pkg::CM_CH_HI:0];
  assign INPUT_DISABLE = s_r.ch_mode[sadc_pkg::CM_INDIS];
  assign LADDER_ON = s_r.ladder;
  assign CONV_ACTIVE = t_busy;
  assign CONV_DONE_IRQ = s_r.irq;

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  sequence start_s;
    go;
  endsequence

  sequence running_s;
    t_busy && !s_r.ch_mode[sadc_pkg::CM_START];
  endsequence

  sequence complete_s;
    s_r.done && CONV_DONE_IRQ;
  endsequence

  start_clears_a: assert property (start_s |=> running_s)
    else $error("start bit not cleared or busy not set");
  reserved_mode_a: assert property (mode == sadc_pkg::MODE_RSVD |-> !go)
    else $error("conversion started in the reserved mode");
  done_store_a: assert property (t_done && !STANDBY |=> complete_s
    and (s_r.result == $past(s_r.res_s2)))
    else $error("completion did not store result and raise done");
  standby_init_a: assert property (STANDBY |=> !t_busy
    && s_r.ch_mode == sadc_pkg::CH_MODE_RST
    && s_r.tim_ladder == sadc_pkg::TIM_LADDER_RST)
    else $error("standby did not reinitialise control");
  high_read_a: assert property (s_r.rd_pend && !t_done && !go
    && s_r.addr == sadc_pkg::ADDR_RES_HIGH |=> !s_r.done)
    else $error("reading the high result left done set");
  abort_drop_a: assert property (wr_cm && t_busy && !t_done && abort
    |=> !t_busy ##1 !CONV_DONE_IRQ)
    else $error("disable did not abort the conversion");
  // A rewrite of the timing register may legally drop the bit
  ladder_on_a: assert property (s_r.tim_ladder[sadc_pkg::TL_LADDER]
    && !STANDBY && !(s_r.wr_pend
    && s_r.addr == sadc_pkg::ADDR_TIM_LADDER) |=> LADDER_ON)
    else $error("ladder dropped while held connected");
  status_read_a: assert property (s_r.rd_pend
    && s_r.addr == sadc_pkg::ADDR_RES_LOW
    |=> HRDATA[7:4] == {$past(s_r.result[1:0]), $past(s_r.done),
    $past(t_busy)} && HRDATA[3:0] == 4'h0)
    else $error("status word does not show result, done and busy");
  undef_bits_a: assert property (s_r.rd_pend
    && s_r.addr == sadc_pkg::ADDR_TIM_LADDER |=> HRDATA[7:6] == 2'h0)
    else $error("upper timing control bits not zero");
  channel_hold_a: assert property (t_busy && !STANDBY
    |=> CHANNEL_SEL == $past(CHANNEL_SEL))
    else $error("channel changed during a conversion");
  new_start_a: assert property (start_s |=> !s_r.done
    && s_r.result == $past(s_r.result))
    else $error("new start kept done or lost the old result");

endmodule // sadc_ctrl

// ### dv/test_sadc_ctrl.sv
module test_sadc_ctrl;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [2:0] tc;
    logic [10:0] n;
    logic [9:0] rin;
    logic [3:0] ch;
    logic ind;
    logic lad;
  } sadc_row_t;

  // Every non-reserved time code once, channel codes at both ends of the legal range
  localparam sadc_row_t ROWS [6] = '{
    '{sadc_pkg::TC_39, 11'h027, 10'h3ff, 4'h0, 1'b0, 1'b0},
    '{sadc_pkg::TC_78, 11'h04e, 10'h000, 4'h7, 1'b1, 1'b1},
    '{sadc_pkg::TC_156, 11'h09c, 10'h2a5, 4'h3, 1'b0, 1'b1},
    '{sadc_pkg::TC_312, 11'h138, 10'h15a, 4'h5, 1'b1, 1'b0},
    '{sadc_pkg::TC_624, 11'h270, 10'h201, 4'h1, 1'b0, 1'b0},
    '{sadc_pkg::TC_1248, 11'h4e0, 10'h1fe, 4'h6, 1'b1, 1'b1}};

  logic clk, rst, hsel, hwrite, standby;
  logic [31:0] haddr, hwdata, d;
  logic [1:0] htrans;
  logic [9:0] rin;
  logic prev, lad_bad;
  wire logic hrdy, hresp, act, irq, indis, lad;
  wire logic [31:0] hrdata;
  wire logic [3:0] chs;
  int n_errors, checks, cnt, len, nirq, k;
  sadc_row_t r;

  // Single slave: its ready output is the bus ready
  sadc_ctrl uut (
    .REF_CLK(clk), .RESET(rst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hrdy), .HREADYOUT(hrdy), .HRESP(hresp), .HRDATA(hrdata),
    .STANDBY(standby), .RESULT_IN(rin), .CHANNEL_SEL(chs),
    .INPUT_DISABLE(indis), .LADDER_ON(lad), .CONV_ACTIVE(act),
    .CONV_DONE_IRQ(irq));

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Watchdog: the longest conversion is 1248 cycles, all tests well below
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    finish_test();
  end

  // Conversion length and ladder watch, sampled mid-cycle to avoid races
  always @(negedge clk) begin
    cnt = (act && !prev) ? 0 : cnt + 1;
    if (act && cnt > 1 && lad !== 1'b1) lad_bad = 1'b1;
    if (irq === 1'b1) begin
      len = cnt;
      nirq++;
    end
    prev = act;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Ready is a flop output, so its pre-edge value is read mid-cycle
  task automatic wait_rdy(output logic [31:0] rd);
    logic ok;
    do begin
      @(negedge clk);
      ok = hrdy;
      rd = hrdata;
      @(posedge clk);
    end while (ok !== 1'b1);
  endtask

  task automatic bus(input logic w, input logic [31:0] a, wd);
    logic [31:0] rd;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy(rd);
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy(rd);
    if (!w) d = rd;
  endtask

  task automatic wr(input logic [31:0] a, wd);
    bus(1'b1, a, wd);
  endtask

  task automatic rdr(input logic [31:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  // Mode first, then the start bit, as software would
  task automatic go(input logic [1:0] m, input logic ind, input logic [3:0] c);
    wr(sadc_pkg::ADDR_CH_MODE, {24'h0, 1'b0, m, ind, c});
    wr(sadc_pkg::ADDR_CH_MODE, {24'h0, 1'b1, m, ind, c});
  endtask

  task automatic wait_done;
    do rdr(sadc_pkg::ADDR_RES_LOW); while (d[5] !== 1'b1);
  endtask

  task automatic regs_zero(input string nm);
    rdr(sadc_pkg::ADDR_CH_MODE);
    chk(nm, d, 32'h0);
    rdr(sadc_pkg::ADDR_TIM_LADDER);
    chk(nm, d[5:0], 32'h0);
  endtask

  task automatic finish_test;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial begin
    {hsel, hwrite, standby, prev, lad_bad} = '0;
    {haddr, hwdata, htrans, rin} = '0;
    {n_errors, checks, cnt, len, nirq} = '0;
    rst = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    regs_zero("reset value");
    rdr(sadc_pkg::ADDR_RES_LOW);
    chk("reset status", d[5:4], 32'h0);
    wr(32'h0000_0ff0, 32'h0000_00ff);
    rdr(32'h0000_0ff0);
    chk("unmapped", d, 32'h0);
    chk("hresp", hresp, 32'h0);
    // Table rows: one single conversion per time code
    for (int i = 0; i < 6; i++) begin
      r = ROWS[i];
      rin <= r.rin;
      wr(sadc_pkg::ADDR_TIM_LADDER, {26'h0, r.lad, 1'b1, r.tc, 1'b0});
      go(sadc_pkg::MODE_SINGLE, r.ind, r.ch);
      rdr(sadc_pkg::ADDR_RES_LOW);
      chk("running status", d[5:4], 32'h1);
      wait_done();
      chk("conv length", len, r.n + 11'h001);
      chk("status", d[7:4], {r.rin[1:0], 2'h2});
      chk("channel", chs, r.ch);
      chk("in disable", indis, r.ind);
      chk("ladder idle", lad, r.lad);
      rdr(sadc_pkg::ADDR_RES_HIGH);
      chk("result high", d, r.rin[9:2]);
      rdr(sadc_pkg::ADDR_RES_LOW);
      chk("done cleared", d[5], 32'h0);
      rdr(sadc_pkg::ADDR_CH_MODE);
      chk("ch_mode", d, {1'b0, sadc_pkg::MODE_SINGLE, r.ind, r.ch});
      rdr(sadc_pkg::ADDR_TIM_LADDER);
      chk("tim_ladder", d[5:0], {r.lad, 1'b1, r.tc, 1'b0});
    end
    chk("ladder busy", lad_bad, 32'h0);
    // Restart before the result is read: done drops, old result stays
    wr(sadc_pkg::ADDR_TIM_LADDER, {26'h1, sadc_pkg::TC_39, 1'b0});
    rin <= 10'h0f1;
    go(sadc_pkg::MODE_SINGLE, 1'b0, 4'h2);
    wait_done();
    rin <= 10'h30e;
    go(sadc_pkg::MODE_SINGLE, 1'b0, 4'h2);
    rdr(sadc_pkg::ADDR_RES_LOW);
    chk("restart status", d[7:5], 32'h2);
    rdr(sadc_pkg::ADDR_RES_HIGH);
    chk("old result", d, 32'h3c);
    wait_done();
    rdr(sadc_pkg::ADDR_RES_HIGH);
    chk("new result", d, 32'hc3);
    // Repeat mode runs on, then mode off aborts with no store
    rin <= 10'h155;
    nirq = 0;
    go(sadc_pkg::MODE_REPEAT, 1'b0, 4'h2);
    repeat (170) @(posedge clk);
    chk("repeat irqs", nirq, 32'h4);
    chk("repeat busy", act, 32'h1);
    rdr(sadc_pkg::ADDR_RES_HIGH);
    chk("repeat result", d, 32'h55);
    rin <= 10'h2aa;
    wr(sadc_pkg::ADDR_CH_MODE, {24'h0, 1'b0, sadc_pkg::MODE_OFF, 5'h2});
    repeat (2) @(posedge clk);
    chk("abort busy", act, 32'h0);
    k = nirq;
    repeat (60) @(posedge clk);
    chk("abort irqs", nirq, k);
    rdr(sadc_pkg::ADDR_RES_HIGH);
    chk("abort result", d, 32'h55);
    // Reserved mode never starts
    go(sadc_pkg::MODE_RSVD, 1'b0, 4'h2);
    repeat (50) @(posedge clk);
    chk("reserved mode", act, 32'h0);
    chk("reserved irqs", nirq, k);
    // Start and channel writes while busy are dropped
    wr(sadc_pkg::ADDR_TIM_LADDER, {26'h1, sadc_pkg::TC_156, 1'b0});
    go(sadc_pkg::MODE_SINGLE, 1'b0, 4'h2);
    wr(sadc_pkg::ADDR_CH_MODE, {24'h0, 1'b1, sadc_pkg::MODE_SINGLE, 5'h5});
    @(negedge clk);
    chk("busy channel", chs, 32'h2);
    wait_done();
    repeat (20) @(posedge clk);
    chk("busy restart", act, 32'h0);
    // Standby mid-conversion clears busy and blocks register writes
    go(sadc_pkg::MODE_SINGLE, 1'b0, 4'h2);
    repeat (20) @(posedge clk);
    standby <= 1'b1;
    repeat (3) @(posedge clk);
    chk("standby busy", act, 32'h0);
    wr(sadc_pkg::ADDR_CH_MODE, 32'h0000_0025);
    regs_zero("standby");
    rdr(sadc_pkg::ADDR_RES_LOW);
    chk("standby status", d[7:4], 32'h0);
    standby <= 1'b0;
    regs_zero("after standby");
    // Reset in mid-run
    go(sadc_pkg::MODE_REPEAT, 1'b1, 4'h4);
    repeat (30) @(posedge clk);
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("reset busy", act, 32'h0);
    regs_zero("mid reset");
    finish_test();
  end

endmodule // test_sadc_ctrl
